// file: fci_bus_cycle.sv
// one read or write cycle on the flash pins
`timescale 1ns/10ps
`include "fci_defines.svh"
module fci_bus_cycle (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        start,
    input  wire logic        is_write,
    input  wire logic [18:0] addr,
    input  wire logic [7:0]  wdata,
    output logic             done,
    output logic [7:0]       rdata,
    output logic [18:0]      address_lines,
    output logic [7:0]       data_lines_out,
    output logic             data_lines_oe_n,
    input  wire logic [7:0]  data_lines_in,
    output logic             chip_sel_n,
    output logic             out_drive_n,
    output logic             write_strobe_n
);
    import fci_pkg::*;

    fci_eng_type state_ff;
    logic [2:0]  cnt_ff;
    logic        wr_ff;
    logic [7:0]  sync1_ff;
    logic [7:0]  sync2_ff;

    // ----------------------------------------------------------------
    // data pin synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff <= 8'h00;
            sync2_ff <= 8'h00;
        end else begin
            sync1_ff <= data_lines_in;
            sync2_ff <= sync1_ff;
        end
    end

    // ----------------------------------------------------------------
    // cycle sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff        <= E_IDLE;
            cnt_ff          <= 3'h0;
            wr_ff           <= 1'b0;
            done            <= 1'b0;
            rdata           <= 8'h00;
            address_lines   <= 19'h00000;
            data_lines_out  <= 8'h00;
            data_lines_oe_n <= 1'b1;
            chip_sel_n      <= 1'b1;
            out_drive_n     <= 1'b1;
            write_strobe_n  <= 1'b1;
        end else begin
            done <= 1'b0;
            case (state_ff)
                E_IDLE: begin
                    if (start) begin
                        address_lines   <= addr;
                        data_lines_out  <= wdata;
                        wr_ff           <= is_write;
                        chip_sel_n      <= 1'b0;
                        data_lines_oe_n <= ~is_write;
                        state_ff        <= E_SETUP;
                    end
                end
                E_SETUP: begin
                    if (wr_ff) begin
                        write_strobe_n <= 1'b0;
                        cnt_ff         <= 3'(`FCI_WP_CYC - 1);
                    end else begin
                        out_drive_n <= 1'b0;
                        cnt_ff      <= 3'(`FCI_RD_CYC - 1);
                    end
                    state_ff <= E_STROBE;
                end
                E_STROBE: begin
                    if (cnt_ff != 3'h0) begin
                        cnt_ff <= cnt_ff - 3'h1;
                    end else begin
                        write_strobe_n <= 1'b1;
                        // output drive rises before chip select
                        out_drive_n    <= 1'b1;
                        if (!wr_ff) begin
                            rdata <= sync2_ff;
                        end
                        state_ff <= E_HOLD;
                    end
                end
                E_HOLD: begin
                    chip_sel_n      <= 1'b1;
                    data_lines_oe_n <= 1'b1;
                    done            <= 1'b1;
                    state_ff        <= E_IDLE;
                end
                default: begin
                    state_ff <= E_IDLE;
                end
            endcase
        end
    end
endmodule

// file: fci_controller.sv
// apb-controlled host sequencer for a byte-wide flash with command writes
//
// Overview of operation
// - Host runs the unprotect sequence before any program or erase.
// - Guard sequences are seven consecutive reads; state changes only when complete.
// - Erase is a 20h setup write then a d0h execute write.
// - Program is 10h setup then address and data write; done within 35 us.
// - A ffh write after setup cancels it and returns to read mode.
// - Unprotect reads 1823h,1820h,1822h,0418h,041bh,0419h,041ah in order.
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`include "fci_defines.svh"
module fci_controller #(
    parameter int ERASE_CYC = `FCI_ERASE_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic [18:0]      address_lines,
    output logic [7:0]       data_lines_out,
    output logic             data_lines_oe_n,
    input  wire logic [7:0]  data_lines_in,
    output logic             chip_sel_n,
    output logic             out_drive_n,
    output logic             write_strobe_n
);
    import fci_pkg::*;

    fci_seq_type state_ff;
    fci_op_type  op_ff;
    logic [18:0] addr_ff;
    logic [7:0]  wdata_ff;
    logic [7:0]  rdata_ff;
    logic [2:0]  step_ff;
    logic        guard_ff;
    logic        timeout_ff;
    logic        refused_ff;
    logic        polling_ff;
    logic        have_prev_ff;
    logic        prev_toggle_ff;
    logic        abort_ff;
    logic [16:0] wait_cnt_ff;
    logic        eng_done;
    logic [7:0]  eng_rdata;

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    wire         apb_setup  = psel & ~penable;
    wire         apb_take   = psel & penable & pready;
    wire         sel_ctrl   = (paddr == `FCI_REG_CTRL);
    wire         sel_addr   = (paddr == `FCI_REG_ADDR);
    wire         sel_wdata  = (paddr == `FCI_REG_WDATA);
    wire         sel_status = (paddr == `FCI_REG_STATUS);
    wire         mapped     = sel_ctrl | sel_addr | sel_wdata | (sel_status & ~pwrite);
    wire         busy       = (state_ff != S_IDLE);
    wire         can_abort  = polling_ff & (fci_op_type'(pwdata[2:0]) == OP_RESET);
    // a command written while busy is refused at the bus, except a reset abort
    wire         busy_err   = pwrite & sel_ctrl & busy & ~can_abort;
    wire         wr_ok      = apb_take & pwrite & ~pslverr;
    wire         ctrl_wr    = wr_ok & sel_ctrl;
    fci_op_type  new_op;
    assign new_op = fci_op_type'(pwdata[2:0]);
    wire         is_array_op = (new_op == OP_PROGRAM) | (new_op == OP_ERASE);
    // no program or erase while guarded
    wire         guard_block = guard_ff & is_array_op;
    wire         go          = ctrl_wr & ~busy & ~guard_block & (new_op != OP_NONE);
    wire         abort_req   = ctrl_wr & can_abort;
    wire [31:0]  status_word = {16'h0000, rdata_ff, 3'b000, prev_toggle_ff, refused_ff,
                                timeout_ff, guard_ff, busy};
    wire [31:0]  rd_mux = sel_ctrl   ? {29'h0, op_ff} :
                          sel_addr   ? {13'h0, addr_ff} :
                          sel_wdata  ? {24'h0, wdata_ff} :
                          sel_status ? status_word : 32'h0;

    // ----------------------------------------------------------------
    // current bus cycle
    // ----------------------------------------------------------------
    // fixed guard read order
    function automatic logic [18:0] guard_addr(input logic protect, input logic [2:0] idx);
        logic [18:0] a;
        a = `FCI_UNP_A0;
        case (idx)
            3'd0: a = `FCI_UNP_A0;
            3'd1: a = `FCI_UNP_A1;
            3'd2: a = `FCI_UNP_A2;
            3'd3: a = `FCI_UNP_A3;
            3'd4: a = `FCI_UNP_A4;
            3'd5: a = `FCI_UNP_A5;
            default: a = protect ? `FCI_PRO_A6 : `FCI_UNP_A6;
        endcase
        return a;
    endfunction

    wire         first     = (step_ff == 3'd0);
    wire         guard_op  = (op_ff == OP_UNPROTECT) | (op_ff == OP_PROTECT);
    wire         array_op  = (op_ff == OP_PROGRAM) | (op_ff == OP_ERASE);
    // program setup then address and data
    wire         cyc_write = ~polling_ff & (array_op | (op_ff == OP_RESET) | ((op_ff == OP_READ_ID) & first));
    // sector from upper address bits only
    wire [18:0]  cyc_addr  = polling_ff                     ? addr_ff :
                             guard_op                       ? guard_addr(op_ff == OP_PROTECT, step_ff) :
                             (op_ff == OP_ERASE) & ~first   ? {addr_ff[18:8], 8'h00} :
                             (op_ff == OP_READ)             ? addr_ff :
                             first                          ? `FCI_ADDR_ANY : addr_ff;
    wire [7:0]   cyc_data  = (op_ff == OP_PROGRAM) ? (first ? `FCI_CMD_PROG : wdata_ff) :
                             (op_ff == OP_ERASE)   ? (first ? `FCI_CMD_ERASE : `FCI_CMD_ERASE_GO) :
                             (op_ff == OP_RESET)   ? `FCI_CMD_RESET :
                             (op_ff == OP_READ_ID) ? `FCI_CMD_READ_ID : 8'h00;
    // seven reads, guard state moves only at the last
    wire         cyc_last  = guard_op ? (step_ff == `FCI_GUARD_LAST) :
                             ((op_ff == OP_READ) | (op_ff == OP_RESET)) ? first : ~first;
    wire [16:0]  poll_lim  = (op_ff == OP_ERASE) ? 17'(ERASE_CYC + `FCI_POLL_SLACK) :
                                                   17'(`FCI_PROG_CYC + `FCI_POLL_SLACK);
    wire         toggle    = eng_rdata[`FCI_TOGGLE_BIT];
    wire         settled   = have_prev_ff & (toggle == prev_toggle_ff);

    // ----------------------------------------------------------------
    // apb slave: one wait-free access phase, answer from flops
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= apb_setup;
            pslverr <= apb_setup & (~mapped | busy_err);
            if (apb_setup) begin
                prdata <= rd_mux;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_ff  <= 19'h00000;
            wdata_ff <= 8'h00;
        end else begin
            if (wr_ok & sel_addr & ~busy) begin
                addr_ff <= pwdata[18:0];
            end
            if (wr_ok & sel_wdata & ~busy) begin
                wdata_ff <= pwdata[7:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // status flags
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            guard_ff   <= 1'b1;
            refused_ff <= 1'b0;
        end else begin
            if (ctrl_wr & ~busy) begin
                refused_ff <= guard_block;
            end
            if ((state_ff == S_WAIT) & eng_done & guard_op & cyc_last & ~polling_ff) begin
                guard_ff <= (op_ff == OP_PROTECT);
            end
        end
    end

    // ----------------------------------------------------------------
    // operation sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff       <= S_IDLE;
            op_ff          <= OP_NONE;
            step_ff        <= 3'd0;
            rdata_ff       <= 8'h00;
            timeout_ff     <= 1'b0;
            polling_ff     <= 1'b0;
            have_prev_ff   <= 1'b0;
            prev_toggle_ff <= 1'b0;
            abort_ff       <= 1'b0;
            wait_cnt_ff    <= 17'h0;
        end else begin
            if (polling_ff) begin
                wait_cnt_ff <= wait_cnt_ff + 17'h1;
            end
            // reset accepted while a program or erase is being waited for
            if (abort_req) begin
                abort_ff <= 1'b1;
            end
            case (state_ff)
                S_IDLE: begin
                    if (go) begin
                        op_ff      <= new_op;
                        step_ff    <= 3'd0;
                        timeout_ff <= 1'b0;
                        state_ff   <= S_ISSUE;
                    end
                end
                S_ISSUE: begin
                    state_ff <= S_WAIT;
                end
                S_WAIT: begin
                    if (eng_done) begin
                        rdata_ff <= eng_rdata;
                        state_ff <= S_ISSUE;
                        if (polling_ff) begin
                            have_prev_ff   <= 1'b1;
                            prev_toggle_ff <= toggle;
                            if (abort_ff | abort_req) begin
                                op_ff      <= OP_RESET;
                                step_ff    <= 3'd0;
                                polling_ff <= 1'b0;
                                abort_ff   <= 1'b0;
                            // two equal bit 6 reads mean done
                            end else if (settled) begin
                                polling_ff <= 1'b0;
                                state_ff   <= S_IDLE;
                            end else if (wait_cnt_ff >= poll_lim) begin
                                // erase or program overran its limit
                                timeout_ff <= 1'b1;
                                polling_ff <= 1'b0;
                                state_ff   <= S_IDLE;
                            end
                        end else if (!cyc_last) begin
                            step_ff <= step_ff + 3'd1;
                        end else if (array_op) begin
                            // wait for completion by status reads
                            polling_ff   <= 1'b1;
                            have_prev_ff <= 1'b0;
                            wait_cnt_ff  <= 17'h0;
                        end else begin
                            state_ff <= S_IDLE;
                        end
                    end
                end
                default: begin
                    state_ff <= S_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // pin cycle engine
    // ----------------------------------------------------------------
    // strobe falls after select, so address is set first
    fci_bus_cycle u_cycle (
        .pclk            (pclk),
        .presetn         (presetn),
        .start           (state_ff == S_ISSUE),
        .is_write        (cyc_write),
        .addr            (cyc_addr),
        .wdata           (cyc_data),
        .done            (eng_done),
        .rdata           (eng_rdata),
        .address_lines   (address_lines),
        .data_lines_out  (data_lines_out),
        .data_lines_oe_n (data_lines_oe_n),
        .data_lines_in   (data_lines_in),
        .chip_sel_n      (chip_sel_n),
        .out_drive_n     (out_drive_n),
        .write_strobe_n  (write_strobe_n)
    );
endmodule

// file: fci_controller_properties.sv
// pin-level properties of the flash command interface controller
`timescale 1ns/10ps
module fci_controller_properties #(
    parameter int ERASE_CYC = 40000
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [18:0] address_lines,
    input wire logic [7:0]  data_lines_out,
    input wire logic        data_lines_oe_n,
    input wire logic        chip_sel_n,
    input wire logic        out_drive_n,
    input wire logic        write_strobe_n
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    write_only_a: assert property (!write_strobe_n |-> !chip_sel_n && out_drive_n && !data_lines_oe_n)
        else $error("strobe outside a write cycle");
    float_read_a: assert property (!out_drive_n |-> data_lines_oe_n && !chip_sel_n)
        else $error("drive fight during read");
    deselect_idle_a: assert property (chip_sel_n |-> write_strobe_n && out_drive_n && data_lines_oe_n)
        else $error("activity while deselected");
    addr_hold_a: assert property (!chip_sel_n && $past(!chip_sel_n) |-> $stable(address_lines))
        else $error("address moved in a cycle");
    data_hold_a: assert property (!data_lines_oe_n && $past(!data_lines_oe_n) |-> $stable(data_lines_out))
        else $error("write data moved");
    addr_first_a: assert property ($fell(write_strobe_n) |-> $past(!chip_sel_n))
        else $error("strobe fell before select");
    strobe_len_a: assert property ($fell(write_strobe_n) |=> write_strobe_n && !chip_sel_n ##1 chip_sel_n)
        else $error("bad strobe pulse");
    read_len_a: assert property ($fell(out_drive_n) |-> !out_drive_n[*5] ##1 !chip_sel_n ##1 chip_sel_n)
        else $error("bad read cycle");
    cover property ($fell(write_strobe_n));
    cover property ($fell(out_drive_n));
    cover property (pready && pslverr);
endmodule
bind fci_controller fci_controller_properties #(.ERASE_CYC(ERASE_CYC)) props (.pclk, .presetn, .pready, .pslverr,
    .address_lines, .data_lines_out, .data_lines_oe_n, .chip_sel_n, .out_drive_n, .write_strobe_n);

// file: fci_controller_tb_top.sv
// self-checking bench for the flash command interface controller
`timescale 1ns/10ps
module fci_controller_tb_top;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err, data_lines_oe_n, chip_sel_n, out_drive_n, write_strobe_n;
    logic [18:0] address_lines;
    logic [7:0]  data_lines_out, data_lines_in;
    int          mismatches = 0;
    int          samples_checked = 0;
    fci_controller #(.ERASE_CYC(200)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .address_lines, .data_lines_out, .data_lines_oe_n, .data_lines_in, .chip_sel_n,
        .out_drive_n, .write_strobe_n);
    fci_flash_model flash (.address_lines, .data_lines_out, .data_lines_oe_n, .chip_sel_n, .out_drive_n,
        .write_strobe_n, .bus(data_lines_in));
    initial forever #50 pclk = ~pclk;
    initial begin
        #3000000;
        mismatches++;
        wrap_up;
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) mismatches++;
        if (got !== exp) $display("BAD %0t got %h exp %h", $time, got, exp);
    endtask
    // bounded poll: a stuck engine gives up after 900 status reads and counts a mismatch instead of hanging
    task automatic run(input logic [2:0] op, input logic [18:0] a, input logic [7:0] d);
        int n;
        n = 0;
        apb(1'b1, 12'h004, {13'h0, a});
        apb(1'b1, 12'h008, {24'h0, d});
        apb(1'b1, 12'h000, {29'h0, op});
        do apb(1'b0, 12'h00c, 32'h0); while (rd[0] !== 1'b0 && ++n < 900);
        chk(rd[0], 1'b0);
    endtask
    task automatic t_start;
        apb(1'b0, 12'h00c, 32'h0);
        chk(rd[3:0], 4'h2);
        chk({chip_sel_n, out_drive_n, write_strobe_n, data_lines_oe_n}, 4'hf);
        apb(1'b1, 12'h010, 32'h1);
        chk(err, 1'b1);
        apb(1'b1, 12'h00c, 32'h0);
        chk(err, 1'b1);
    endtask
    task automatic t_guarded;
        for (int op = 1; op < 3; op++) begin
            run(op[2:0], 19'h00100, 8'h33);
            chk(rd[3], 1'b1);
            chk(flash.mem.size(), 0);
        end
        for (int i = 0; i < 2; i++) begin
            run(3'd4, i[18:0], 8'h00);
            chk(rd[15:8], i ? flash.PART : flash.MAKER);
        end
        run(3'd3, 19'h0, 8'h0);
        run(3'd0, 19'h0, 8'h0);
        chk(rd[15:8], 8'hff);
    endtask
    task automatic t_guard(input logic [2:0] op, input logic g);
        run(op, 19'h0, 8'h0);
        chk(rd[1], g);
        chk(flash.guard_ff, g);
    endtask
    task automatic t_prog_erase;
        logic [18:0] a [2] = '{19'h7ffff, 19'h12345};
        for (int i = 0; i < 2; i++) begin
            run(3'd1, a[i], 8'h5a ^ i[7:0]);
            chk(rd[2], 1'b0);
            chk(flash.mem[a[i]], 8'h5a ^ i[7:0]);
            run(3'd0, a[i], 8'h0);
            chk(rd[15:8], 8'h5a ^ i[7:0]);
        end
        run(3'd2, 19'h123ff, 8'h0);
        chk(rd[2], 1'b0);
        chk(flash.ea, 19'h12300);
        run(3'd0, 19'h12345, 8'h0);
        chk(rd[15:8], 8'hff);
        chk(flash.mem[19'h7ffff], 8'h5a);
    endtask
    task automatic t_abort;
        apb(1'b1, 12'h000, 32'h2);
        apb(1'b1, 12'h000, 32'h0);
        chk(err, 1'b1);
        // abort is only taken once completion polling has begun
        @(negedge out_drive_n);
        apb(1'b1, 12'h000, 32'h3);
        chk(err, 1'b0);
        run(3'd7, 19'h0, 8'h0);
        chk(flash.busy, 1'b0);
        chk(flash.guard_ff, 1'b0);
    endtask
    task automatic wrap_up;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_start;
        t_guarded;
        t_guard(3'd5, 1'b0);
        t_prog_erase;
        t_abort;
        t_guard(3'd6, 1'b1);
        wrap_up;
    end
endmodule

// file: fci_defines.svh
// constants for the flash command interface controller
`ifndef FCI_DEFINES_SVH
`define FCI_DEFINES_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define FCI_CLK_NS        100
`define FCI_T_ACC_NS      200
`define FCI_T_WP_NS       100
`define FCI_T_PROG_NS     35000
`define FCI_T_ERASE_NS    4000000
// least times round up, longest times round down
`define FCI_ACC_CYC       ((`FCI_T_ACC_NS + `FCI_CLK_NS - 1) / `FCI_CLK_NS)
`define FCI_WP_CYC        ((`FCI_T_WP_NS + `FCI_CLK_NS - 1) / `FCI_CLK_NS)
`define FCI_PROG_CYC      (`FCI_T_PROG_NS / `FCI_CLK_NS)
`define FCI_ERASE_CYC     (`FCI_T_ERASE_NS / `FCI_CLK_NS)
`define FCI_SYNC_CYC      2
// output drive low time: access time, synchroniser, one cycle margin
`define FCI_RD_CYC        (`FCI_ACC_CYC + `FCI_SYNC_CYC + 1)
// extra cycles for the two confirming status reads after the limit
`define FCI_POLL_SLACK    64

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define FCI_REG_CTRL      12'h000
`define FCI_REG_ADDR      12'h004
`define FCI_REG_WDATA     12'h008
`define FCI_REG_STATUS    12'h00c
`define FCI_ST_BUSY       0
`define FCI_ST_GUARD      1
`define FCI_ST_TIMEOUT    2
`define FCI_ST_REFUSED    3
`define FCI_ST_TOGGLE     4

// ----------------------------------------------------------------
// device commands and addresses
// ----------------------------------------------------------------
`define FCI_CMD_PROG      8'h10
`define FCI_CMD_ERASE     8'h20
`define FCI_CMD_ERASE_GO  8'hd0
`define FCI_CMD_RESET     8'hff
`define FCI_CMD_READ_ID   8'h90
`define FCI_ADDR_ANY      19'h00000
`define FCI_TOGGLE_BIT    6
`define FCI_GUARD_LAST    3'd6
`define FCI_UNP_A0        19'h01823
`define FCI_UNP_A1        19'h01820
`define FCI_UNP_A2        19'h01822
`define FCI_UNP_A3        19'h00418
`define FCI_UNP_A4        19'h0041b
`define FCI_UNP_A5        19'h00419
`define FCI_UNP_A6        19'h0041a
`define FCI_PRO_A6        19'h0040a

`endif

// file: fci_flash_model.sv
// behavioural flash device answering the controller's pins
`timescale 1ns/10ps
module fci_flash_model #(
    parameter int         PROG_NS  = 30000,
    parameter int         ERASE_NS = 8000,
    // identity bytes: arbitrary values
    parameter logic [7:0] MAKER    = 8'h5c,
    parameter logic [7:0] PART     = 8'h3e
) (
    input  wire logic [18:0] address_lines,
    input  wire logic [7:0]  data_lines_out,
    input  wire logic        data_lines_oe_n,
    input  wire logic        chip_sel_n,
    input  wire logic        out_drive_n,
    input  wire logic        write_strobe_n,
    output logic [7:0]       bus
);
    logic [7:0]  mem [int];
    logic [18:0] wa, ea;
    logic [7:0]  drv = 8'h00, ld, d;
    logic        guard_ff = 1'b1, busy = 1'b0, tog = 1'b0, prog = 1'b0, pg, er;
    int          mode = 0, ui = 0, pi = 0;
    realtime     done_t = 0;
    wire         rd_n = chip_sel_n | out_drive_n;
    wire         wr_n = chip_sel_n | write_strobe_n | ~out_drive_n;
    // float when idle; no pull, so released lines show the inverse
    assign bus = !data_lines_oe_n ? data_lines_out : !rd_n ? drv : ~drv;
    function automatic logic [18:0] step(int i, bit p);
        logic [18:0] t [7] = '{19'h01823, 19'h01820, 19'h01822, 19'h00418, 19'h0041b, 19'h00419, 19'h0041a};
        return (p && i == 6) ? 19'h0040a : t[i];
    endfunction
    always #10 busy = $realtime < done_t;
    always @(negedge rd_n) begin
        drv = busy ? {prog & ~ld[7], tog, 6'h00} : mode == 3 ? (address_lines[0] ? PART : MAKER)
            : mem.exists(address_lines) ? mem[address_lines] : 8'hff;
        tog = tog ^ busy;
    end
    always @(posedge rd_n) begin
        ui = address_lines == step(ui, 0) ? ui + 1 : int'(address_lines == 19'h01823);
        pi = address_lines == step(pi, 1) ? pi + 1 : int'(address_lines == 19'h01823);
        if (ui == 7 || pi == 7) begin
            guard_ff = pi == 7;
            ui = 0;
            pi = 0;
        end
    end
    always @(negedge wr_n) wa = address_lines;
    always @(posedge wr_n) begin
        d = bus;
        drv = d;
        ui = 0;
        pi = 0;
        pg = mode == 1 && d != 8'hff;
        er = mode == 2 && d == 8'hd0;
        if (pg) mem[wa] = d;
        if (pg) ld = d;
        if (er) ea = {wa[18:8], 8'h00};
        for (int i = 0; i < 256; i++) if (er) mem.delete({wa[18:8], i[7:0]});
        if (pg || er) prog = pg;
        if (pg || er) done_t = $realtime + (pg ? PROG_NS : ERASE_NS);
        if (d == 8'hff) done_t = $realtime;
        mode = pg || er || (guard_ff && d != 8'h90) ? 0 : d == 8'h10 ? 1 : d == 8'h20 ? 2 : d == 8'h90 ? 3 : 0;
    end
endmodule

// file: fci_pkg.sv
// types for the flash command interface controller
package fci_pkg;
    typedef enum logic [2:0] {
        OP_READ      = 3'b000,
        OP_PROGRAM   = 3'b001,
        OP_ERASE     = 3'b010,
        OP_RESET     = 3'b011,
        OP_READ_ID   = 3'b100,
        OP_UNPROTECT = 3'b101,
        OP_PROTECT   = 3'b110,
        OP_NONE      = 3'b111
    } fci_op_type;

    typedef enum logic [1:0] {
        S_IDLE  = 2'b00,
        S_ISSUE = 2'b01,
        S_WAIT  = 2'b10
    } fci_seq_type;

    typedef enum logic [1:0] {
        E_IDLE   = 2'b00,
        E_SETUP  = 2'b01,
        E_STROBE = 2'b10,
        E_HOLD   = 2'b11
    } fci_eng_type;
endpackage
